// ==== dv/grabber_model.sv ====
// Receiver model that counts frame and line starts on the sync lane
`timescale 1ns/10ps
`include "seq_params.svh"
module grabber_model (
  input wire logic lane_clk,
  input wire logic lane_sync,
  output int fs_cnt,
  output int ls_cnt
);
  logic [9:0] sh = 10'h000;
  initial fs_cnt = 0;
  initial ls_cnt = 0;
  // Rising edge is mid-bit, since bits move as the clock falls
  always @(posedge lane_clk) begin
    sh = {sh[8:0], lane_sync};
    if (sh == `SYNC_FS) fs_cnt++;
    if (sh == `SYNC_LS) ls_cnt++;
  end
endmodule

// ==== dv/image_sensor_sequencer_assertions.sv ====
// Port checks of the sensor sequencer
`timescale 1ns/10ps
module image_sensor_sequencer_assertions #(parameter int LANES = 32) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_take,
  input wire logic row_read,
  input wire logic row_reset,
  input wire logic pix_reset_all,
  input wire logic pix_sample_all,
  input wire logic [LANES-1:0] lane_data,
  input wire logic lane_clk,
  input wire logic seq_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence no_row;
    !row_read [*8];
  endsequence
  sequence run2;
    seq_running && $past(seq_running);
  endsequence
  ready_tied_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray error");
  stat_ok_a: assert property (psel && penable && paddr == 12'h310 |-> !pslverr)
    else $error("status access refused");
  fot_gap_a: assert property (pix_sample_all |=> no_row) else $error("row in overhead");
  rst_pair_a: assert property (row_reset |-> row_read) else $error("lone reset row");
  run_gate_a: assert property (pix_reset_all || adc_take |-> seq_running)
    else $error("capture while idle");
  clk_fwd_a: assert property (run2 |-> lane_clk != $past(lane_clk))
    else $error("lane clock stuck");
  bit_edge_a: assert property (run2 ##0 $changed(lane_data) |-> !lane_clk)
    else $error("bit moved off edge");
endmodule
bind image_sensor_sequencer image_sensor_sequencer_assertions #(.LANES(LANES)) chk (.clk,
  .rst, .psel, .penable, .paddr, .pready, .pslverr, .adc_take, .row_read, .row_reset,
  .pix_reset_all, .pix_sample_all, .lane_data, .lane_clk, .seq_running);

// ==== dv/tb_top.sv ====
// Bench for the sensor sequencer
`timescale 1ns/10ps
`include "seq_params.svh"
module tb_top;
  import seq_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, trig_in = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, lane_data;
  logic [63:0][9:0] adc_data = '0;
  logic [15:0] rd_row, rst_row;
  logic [1:0] expo = 2'h0;
  logic pready, pslverr, adc_take, row_read, row_reset, pix_reset_all, pix_sample_all;
  logic lane_clk, lane_sync, seq_running;
  logic [31:0] md [6] = '{32'h1, 32'hD, 32'h41, 32'h21, 32'h31, 32'h11};
  int mismatches = 0, compares = 0, smp = 0, fs_cnt, ls_cnt, k, k2;
  initial forever #12.5 clk = ~clk;
  image_sensor_sequencer #(.ROW_WORDS(4), .ROWS(4), .ROT_CYC(2)) DUT (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trig_in, .adc_data,
    .adc_take, .rd_row, .rst_row, .row_read, .row_reset, .pix_reset_all, .pix_sample_all,
    .lane_data, .lane_clk, .lane_sync, .seq_running);
  grabber_model RX (.lane_clk, .lane_sync, .fs_cnt, .ls_cnt);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [5:0] pexp(input logic [2:0] b);
    return b[2] ? PW_IDLE : (b[1] ? PW_STBY2 : (b[0] ? PW_STBYI : PW_STBY1));
  endfunction
  task automatic stat(input logic [5:0] e);
    apb(1'b0, `IDX_STAT, 32'h0);
    chk(rd[5:0], e);
  endtask
  task automatic pw(input logic [2:0] b);
    apb(1'b1, `IDX_PWR, {29'h0, b});
    stat(pexp(b));
  endtask
  task automatic seq(input logic [31:0] m);
    apb(1'b1, `IDX_SEQ, m);
    stat(m[0] ? PW_RUN : PW_IDLE);
  endtask
  // Bounded so a silent lane cannot hang the run
  task automatic waitc(input logic f, input int t);
    int c;
    c = 0;
    while ((f ? fs_cnt : smp) < t && c < 20000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task conclude;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    for (int j = 0; j < 64; j++) adc_data[j] <= 10'($urandom);
    if (pix_sample_all === 1'b1) smp <= smp + 1;
    if (row_reset === 1'b1) chk(rst_row, 16'((rd_row + expo) % 4));
  end
  initial begin
    #1500000;
    mismatches++;
    conclude;
  end
  initial begin
    void'($urandom(30262));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    stat(PW_STBY1);
    repeat (400) @(posedge clk);
    apb(1'b0, `IDX_EXPO, 32'h0);
    chk(rd, `EXPO_RST);
    apb(1'b0, 10'h3E8, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `IDX_INTEG, 32'h5);
    chk(er, 1'b1);
    apb(1'b0, `IDX_INTEG, 32'h0);
    chk(rd, `INTEG_RST);
    pw(3'h1);
    pw(3'h3);
    apb(1'b1, `IDX_INTEG, $urandom_range(8, 64));
    chk(er, 1'b0);
    pw(3'h7);
    chk(seq_running, 1'b0);
    apb(1'b1, `IDX_LANE, 32'h3);
    apb(1'b0, `IDX_LANE, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `IDX_LANE, 32'h0);
    $display("power test done");
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        expo = 2'($urandom);
        apb(1'b1, `IDX_EXPO, {30'h0, expo});
      end
      seq(md[i]);
      k = fs_cnt;
      waitc(1'b1, k + 2);
      chk(fs_cnt >= k + 2, 1'b1);
      chk(ls_cnt > 0, 1'b1);
      seq(md[i] & 32'hFFFFFFFE);
      chk(seq_running, 1'b0);
    end
    $display("streaming test done");
    for (int i = 3; i < 6; i++) begin
      seq(md[i]);
      repeat (3) begin
        k = smp;
        @(posedge clk);
        trig_in <= 1'b1;
        repeat ($urandom_range(10, 40)) @(posedge clk);
        trig_in <= 1'b0;
        waitc(1'b0, k + 1);
        k2 = fs_cnt;
        waitc(1'b1, k2 + 1);
        chk(smp - k, 1);
      end
      seq(md[i] & 32'hFFFFFFFE);
    end
    $display("trigger test done");
    conclude;
  end
endmodule

// ==== hdl/image_sensor_sequencer.sv ====
// Sensor readout sequencer, power states, line formatting and lane serializer
// How it works
// - Each lane interleaves two converter channels
// - Per-lane CRC sent once each line
// - Sync lane marks frame/line start and end
// - Lane bit rate limited, 10 or 8-bit words
// - Data lanes plus clock lane and sync lane
// - Half-lane mode doubles words, halves rate
// - Global: reset all, sample all, read rows
// - Pipelined: integrate next during current readout
// - Frame overhead first, row overhead per row
// - Pipelined master times integration from register
// - Pipelined slave: trigger high integrates, fall reads
// - Triggered: one frame per action, then idle
// - Triggered master: rise starts timed frame
// - Triggered slave: pin level frames integration, readout
// - Rolling: reset and read pointers set exposure
// - Exposure change taken at frame boundary
// - Zero overhead: no row gap between rows
// - Six power states ordered by dissipation
// - First standby: only indices below 40 writable
// - Second standby: all registers accessible
// - Clock bit enters intermediate standby, reserved upload advances
// - Idle until sequencer enable bit is set
// - Control word enables sequencer, bit 0 stops
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "seq_params.svh"
module image_sensor_sequencer import seq_pkg::*; #(
  parameter int LANES = `N_LANES,
  parameter int ROW_WORDS = 128,
  parameter int ROWS = 4096,
  parameter int FOT_CYC = 64,
  parameter int ROT_CYC = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_in,
  input wire logic [2*LANES-1:0][9:0] adc_data,
  output logic adc_take,
  output logic [15:0] rd_row,
  output logic [15:0] rst_row,
  output logic row_read,
  output logic row_reset,
  output logic pix_reset_all,
  output logic pix_sample_all,
  output logic [LANES-1:0] lane_data,
  output logic lane_clk,
  output logic lane_sync,
  output logic seq_running
);
  typedef struct packed {
    pwr_t ps;
    sq_t sq;
    logic [2:0] pwr;
    logic [15:0] seq;
    logic [15:0] integ;
    logic [15:0] expo;
    logic [15:0] expo_sh;
    logic [1:0] lcfg;
    logic [31:0] rdat;
    logic t1;
    logic t2;
    logic td;
    logic ibusy;
    logic fpend;
    logic [15:0] icnt;
    logic [15:0] cnt;
    logic [15:0] row;
    logic [15:0] word;
    logic [15:0] frames;
    logic [3:0] bitc;
    logic half;
    logic [LANES-1:0][9:0] sh;
    logic [LANES-1:0][9:0] crc;
    logic [9:0] ssh;
    logic prst;
    logic psmp;
    logic rrd;
    logic rrs;
  } st_t;

  localparam int HL = LANES / 2;

  st_t s;
  st_t n;
  logic [LANES-1:0][9:0] lw;
  logic [LANES-1:0][9:0] lcrc;
  logic [LANES-1:0][9:0] lsh;
  logic [15:0] ldw;
  ld_t ld;

  function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d);
    logic [9:0] r;
    r = c;
    for (int i = 9; i >= 0; i--) begin
      r = {r[8:0], 1'b0} ^ ((r[9] ^ d[i]) ? `CRC_POLY : 10'h000);
    end
    return r;
  endfunction

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [9:0] pick;
    logic [9:0] val;
    // Half mode: low lanes also carry the pairs of the upper lanes
    assign pick = (s.lcfg[`LANE_HALF] && ldw[1]) ?
                  (ldw[0] ? adc_data[2*((g+HL)%LANES)+1] : adc_data[2*((g+HL)%LANES)]) :
                  (ldw[0] ? adc_data[2*g+1] : adc_data[2*g]);
    assign val = (s.lcfg[`LANE_HALF] && g >= HL) ? 10'h000 :
                 (s.lcfg[`LANE_BIT8] ? {pick[9:2], 2'b00} : pick);
    assign lw[g] = val;
    // Checksum restarts with the first word of every line
    assign lcrc[g] = crc_step((ldw == 16'h0000) ? 10'h000 : s.crc[g], val);
    assign lsh[g] = {s.sh[g][8:0], 1'b0};
    assign lane_data[g] = s.sh[g][9];
  end

  always_comb begin
    logic wr;
    logic setup;
    logic hit;
    logic allow;
    logic run;
    logic slave;
    logic trg;
    logic roll;
    logic zrot;
    logic rise;
    logic fall;
    logic slot_end;
    logic last_row;
    logic [3:0] ww;
    logic [15:0] nw;
    logic [9:0] idx;
    logic [16:0] rsum;
    n = s;
    ld = LD_IDLE;
    ldw = 16'h0000;
    idx = paddr[11:2];
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    hit = (idx == `IDX_PWR) || (idx == `IDX_SEQ) || (idx == `IDX_INTEG) ||
          (idx == `IDX_EXPO) || (idx == `IDX_LANE) || (idx == `IDX_STAT);
    allow = (s.ps != PW_OFF) && ((s.ps != PW_STBY1) || (idx < `STBY1_LIMIT));
    // Gated by the enables too, so no pulse escapes on the edge that leaves running
    run = (s.ps == PW_RUN) && s.seq[`SEQ_EN] && s.pwr[`PWR_BLK];
    slave = s.seq[`SEQ_SLAVE];
    trg = s.seq[`SEQ_TRIG];
    roll = s.seq[`SEQ_ROLL];
    zrot = s.seq[`SEQ_ZROT];
    ww = s.lcfg[`LANE_BIT8] ? `WW8 : `WW10;
    nw = s.lcfg[`LANE_HALF] ? 16'(2 * ROW_WORDS) : 16'(ROW_WORDS);
    slot_end = s.half && (s.bitc == ww - 4'd1);
    last_row = (s.row == 16'(ROWS - 1));
    n.prst = 1'b0;
    n.psmp = 1'b0;
    n.rrd = 1'b0;
    n.rrs = 1'b0;
    // Trigger pin is asynchronous; edges are found from the second and third stages
    n.t1 = trig_in;
    n.t2 = s.t1;
    n.td = s.t2;
    rise = s.t2 && !s.td;
    fall = !s.t2 && s.td;

    if (setup) begin
      case (idx)
        `IDX_PWR: n.rdat = {29'h0, s.pwr};
        `IDX_SEQ: n.rdat = {16'h0, s.seq};
        `IDX_INTEG: n.rdat = {16'h0, s.integ};
        `IDX_EXPO: n.rdat = {16'h0, s.expo};
        `IDX_LANE: n.rdat = {30'h0, s.lcfg};
        `IDX_STAT: n.rdat = {s.frames, 6'h00, s.sq, s.ps};
        default: n.rdat = 32'h0000_0000;
      endcase
    end
    if (wr && hit && allow) begin
      case (idx)
        `IDX_PWR: n.pwr = pwdata[2:0];
        `IDX_SEQ: n.seq = pwdata[15:0];
        `IDX_INTEG: n.integ = pwdata[15:0];
        `IDX_EXPO: n.expo = pwdata[15:0];
        `IDX_LANE: n.lcfg = pwdata[1:0];
        default: n.lcfg = s.lcfg;
      endcase
    end

    // Power ladder; off is left at the first edge after reset
    case (s.ps)
      PW_OFF: n.ps = PW_STBY1;
      PW_STBY1: if (s.pwr[`PWR_CLK]) n.ps = PW_STBYI;
      PW_STBYI: begin
        if (!s.pwr[`PWR_CLK]) n.ps = PW_STBY1;
        else if (s.pwr[`PWR_RSV]) n.ps = PW_STBY2;
      end
      PW_STBY2: begin
        if (!s.pwr[`PWR_RSV]) n.ps = PW_STBYI;
        else if (s.pwr[`PWR_BLK]) n.ps = PW_IDLE;
      end
      PW_IDLE: begin
        if (!s.pwr[`PWR_BLK]) n.ps = PW_STBY2;
        else if (s.seq[`SEQ_EN]) n.ps = PW_RUN;
      end
      PW_RUN: if (!s.seq[`SEQ_EN] || !s.pwr[`PWR_BLK]) n.ps = PW_IDLE;
      default: n.ps = PW_STBY1;
    endcase

    // Integration runs apart from readout so the two overlap
    if (run && !roll) begin
      if (slave) begin
        if (rise && !s.ibusy) begin
          n.ibusy = 1'b1;
          n.prst = 1'b1;
        end else if (fall && s.ibusy) begin
          n.ibusy = 1'b0;
          n.fpend = 1'b1;
        end
      end else if (s.ibusy) begin
        if (s.icnt == 16'h0000) begin
          n.ibusy = 1'b0;
          n.fpend = 1'b1;
        end else begin
          n.icnt = s.icnt - 16'h0001;
        end
      end else if (!s.fpend && (trg ? rise : 1'b1)) begin
        n.ibusy = 1'b1;
        n.icnt = s.integ;
        n.prst = 1'b1;
      end
    end

    n.half = !s.half;
    if (s.half) begin
      n.bitc = slot_end ? 4'd0 : s.bitc + 4'd1;
      if (!slot_end) begin
        n.sh = lsh;
        n.ssh = {s.ssh[8:0], 1'b0};
      end
    end

    case (s.sq)
      SQ_IDLE: begin
        if (run && roll) begin
          n.sq = SQ_ROT;
          n.row = 16'h0000;
          n.expo_sh = s.expo;
          n.cnt = 16'(ROT_CYC - 1);
        end else if (run && s.fpend) begin
          n.sq = SQ_FOT;
          n.fpend = 1'b0;
          n.psmp = 1'b1;
          n.cnt = 16'(FOT_CYC - 1);
        end
      end
      SQ_FOT: begin
        if (s.cnt == 16'h0000) begin
          n.sq = SQ_ROT;
          n.row = 16'h0000;
          n.cnt = 16'(ROT_CYC - 1);
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
      SQ_ROT: begin
        if (s.cnt != 16'h0000) begin
          n.cnt = s.cnt - 16'h0001;
        end else if (slot_end) begin
          n.sq = SQ_RD;
          n.word = 16'h0000;
          ld = LD_DATA;
        end
      end
      SQ_RD: begin
        if (slot_end) begin
          if (s.word < nw) begin
            n.word = s.word + 16'h0001;
            ldw = n.word;
            ld = (n.word == nw) ? LD_CRC : LD_DATA;
          end else if (!last_row) begin
            n.row = s.row + 16'h0001;
            n.word = 16'h0000;
            if (zrot) begin
              ld = LD_DATA;
            end else begin
              n.sq = SQ_ROT;
              n.cnt = 16'(ROT_CYC - 1);
            end
          end else begin
            n.frames = s.frames + 16'h0001;
            if (roll) begin
              n.sq = SQ_ROT;
              n.row = 16'h0000;
              n.expo_sh = s.expo;
              n.cnt = 16'(ROT_CYC - 1);
            end else if (s.fpend) begin
              n.sq = SQ_FOT;
              n.fpend = 1'b0;
              n.psmp = 1'b1;
              n.cnt = 16'(FOT_CYC - 1);
            end else begin
              n.sq = SQ_IDLE;
            end
          end
        end
      end
      default: n.sq = SQ_IDLE;
    endcase

    if (!run) begin
      ld = LD_IDLE;
      ldw = 16'h0000;
    end
    // Loads happen only on word-slot boundaries so the lane clock never glitches
    if (slot_end) begin
      case (ld)
        LD_DATA: begin
          n.sh = lw;
          n.crc = lcrc;
          n.ssh = (ldw != 16'h0000) ? `SYNC_DATA :
                  ((n.row == 16'h0000) ? `SYNC_FS : `SYNC_LS);
          if (ldw == 16'h0000) begin
            n.rrd = 1'b1;
            n.rrs = roll;
          end
        end
        LD_CRC: begin
          n.sh = s.crc;
          n.ssh = last_row ? `SYNC_FE : `SYNC_LE;
        end
        default: begin
          n.sh = '0;
          n.ssh = `SYNC_IDLE;
        end
      endcase
    end

    if (!run) begin
      n.sq = SQ_IDLE;
      n.ibusy = 1'b0;
      n.fpend = 1'b0;
    end
    rsum = {1'b0, s.row} + {1'b0, s.expo_sh};
    rst_row = (rsum >= 17'(ROWS)) ? 16'(rsum - 17'(ROWS)) : rsum[15:0];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ps <= PW_OFF;
      s.sq <= SQ_IDLE;
      s.integ <= `INTEG_RST;
      s.expo <= `EXPO_RST;
      s.ssh <= `SYNC_IDLE;
    end else begin
      s <= n;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!hit_w() || (pwrite && !allow_w()));
  assign prdata = s.rdat;
  assign adc_take = slot_end_w() && (ld == LD_DATA);
  assign rd_row = s.row;
  assign row_read = s.rrd;
  assign row_reset = s.rrs;
  assign pix_reset_all = s.prst;
  assign pix_sample_all = s.psmp;
  assign lane_clk = s.half;
  assign lane_sync = s.ssh[9];
  assign seq_running = (s.ps == PW_RUN);

  function automatic logic hit_w();
    logic [9:0] i;
    i = paddr[11:2];
    return (i == `IDX_PWR) || (i == `IDX_SEQ) || (i == `IDX_INTEG) ||
           (i == `IDX_EXPO) || (i == `IDX_LANE) || (i == `IDX_STAT);
  endfunction

  function automatic logic allow_w();
    return (s.ps != PW_OFF) && ((s.ps != PW_STBY1) || (paddr[11:2] < `STBY1_LIMIT));
  endfunction

  function automatic logic slot_end_w();
    return s.half && (s.bitc == (s.lcfg[`LANE_BIT8] ? `WW8 : `WW10) - 4'd1);
  endfunction
endmodule

// ==== hdl/seq_params.svh ====
// Register indices, field positions, codes and reset values of the sequencer
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define N_LANES 32
`define IDX_PWR 10'd32
`define IDX_SEQ 10'd192
`define IDX_INTEG 10'd193
`define IDX_EXPO 10'd194
`define IDX_LANE 10'd195
`define IDX_STAT 10'd196
`define STBY1_LIMIT 10'd40
`define PWR_CLK 0
`define PWR_RSV 1
`define PWR_BLK 2
`define SEQ_EN 0
`define SEQ_ZROT 2
`define SEQ_SLAVE 4
`define SEQ_TRIG 5
`define SEQ_ROLL 6
`define LANE_HALF 0
`define LANE_BIT8 1
`define INTEG_RST 16'h0100
`define EXPO_RST 16'h0010
`define WW10 4'd10
`define WW8 4'd8
`define SYNC_FS 10'h3A0
`define SYNC_LS 10'h2A0
`define SYNC_FE 10'h3B0
`define SYNC_LE 10'h2B0
`define SYNC_DATA 10'h035
`define SYNC_IDLE 10'h0E9
`define SYNC_CRC 10'h15A
`define CRC_POLY 10'h233
`endif

// ==== hdl/seq_pkg.sv ====
// Types shared by the sensor sequencer
package seq_pkg;
  typedef enum logic [5:0] {
    PW_OFF = 6'h01,
    PW_STBY1 = 6'h02,
    PW_STBYI = 6'h04,
    PW_STBY2 = 6'h08,
    PW_IDLE = 6'h10,
    PW_RUN = 6'h20
  } pwr_t;
  typedef enum logic [3:0] {
    SQ_IDLE = 4'h1,
    SQ_FOT = 4'h2,
    SQ_ROT = 4'h4,
    SQ_RD = 4'h8
  } sq_t;
  typedef enum logic [1:0] {
    LD_IDLE = 2'h0,
    LD_DATA = 2'h1,
    LD_CRC = 2'h2
  } ld_t;
endpackage
